// [src/olcp_pkg.sv]
// Shared constants and carrier types for the one-time lock and complement
// protect block of the serial flash status logic.
// Assumes a single 10 MHz clock domain and an 8-bit register port.
package olcp_pkg;

  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets on the plain register port.
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h00;
  localparam logic [7:0] ADDR_BP_CTRL = 8'h01;

  // Field positions inside the second status register.
  localparam int INV_BIT = 6;
  localparam int LOCK_LSB = 3;
  localparam int LOCK_W = 3;

  // Field position of the block protect field in its control register.
  localparam int BP_LSB = 0;
  localparam int BP_W = 3;

  // Reset values.
  localparam logic INV_RST = 1'b0;
  localparam logic [2:0] LOCK_RST = 3'h0;
  localparam logic [2:0] BP_RST = 3'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Security register geometry: four registers of 128 bytes each.
  localparam int SEC_REGS = 4;
  localparam int SEC_BYTES = 128;
  localparam int SEC_AW = 7;
  localparam int SEC_SEL_W = 2;
  localparam logic [6:0] SEC_LAST_BYTE = 7'h7F;
  localparam logic [1:0] SEC_FACTORY_SEL = 2'h0;

  // Main array geometry: sixteen 64 kB blocks.
  localparam int BLK_W = 4;
  localparam logic [4:0] NUM_BLKS = 5'h10;

  // One program request for a security register byte.
  typedef struct packed {
    logic [1:0] sel;
    logic [6:0] addr;
    logic [7:0] data;
  } olcp_prog_req_t;

  // One read request for a security register byte.
  typedef struct packed {
    logic [1:0] sel;
    logic [6:0] addr;
  } olcp_sec_rd_t;

endpackage

// [src/olcp_sec_store.sv]
// Byte store for the four security registers.
// Assumes the caller has already decided whether a write is allowed.
module olcp_sec_store (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic wr_en_in,
  input wire logic [1:0] wr_sel_in,
  input wire logic [6:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [1:0] rd_sel_in,
  input wire logic [6:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  // Storage for all four registers, indexed by select and byte offset.
  // It has no reset because it stands for non-volatile cells.
  logic [7:0] mem_q [olcp_pkg::SEC_REGS * olcp_pkg::SEC_BYTES];

  // Read data register, loaded one cycle after a read request.
  logic [7:0] rd_data_q;

  // Flat indices for write and read.
  logic [8:0] wr_idx;
  logic [8:0] rd_idx;

  assign wr_idx = {wr_sel_in, wr_addr_in};
  assign rd_idx = {rd_sel_in, rd_addr_in};

  // The array is only written when the guard in the top allows it.
  always_ff @(posedge ref_clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_idx] <= wr_data_in;
    end
  end

  // Read data holds until the next read so the caller may sample late.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rd_data_q <= olcp_pkg::RDATA_RST;
    end else if (rd_en_in) begin
      rd_data_q <= mem_q[rd_idx];
    end
  end

  assign rd_data_out = rd_data_q;

endmodule

// [src/olcp_top.sv]
// Lock and complement protect logic of the second status register.
// Holds the invert bit, the three one-time lock bits and the block
// protect field, guards security register programming and flags
// whether a main array block is write protected.
// Assumes a single 10 MHz clock, an 8-bit register port driven by
// same-clock logic, and external non-volatile lock cells whose image
// arrives on a pin from outside the clock domain.
//
// Chosen here: the register addresses and the strobed register port.

// What this block does
// [R1] Programming byte 128 sets that lock bit.
// [R2] Lock bits: reg3 bit5, reg2 bit4, reg1 bit3.
// [R3] Lock bits start as zero, all unlocked.
// [R4] A set lock rejects further programming forever.
// [R5] Security register zero is always locked.
// [R6] Invert bit six, read-write, resets to zero.
// [R7] Invert swaps protected and unprotected regions.
// [R8] Invert combines with block protect field.
// [R9] Only reset clears the lock bits; the cell image restores them after it.
module olcp_top (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic prog_valid_in,
  input wire olcp_pkg::olcp_prog_req_t prog_req_in,
  output logic prog_ack_out,
  output logic prog_reject_out,
  input wire logic sec_rd_in,
  input wire olcp_pkg::olcp_sec_rd_t sec_rd_req_in,
  output logic [7:0] sec_rdata_out,
  input wire logic [3:0] arr_block_in,
  output logic arr_protected_out,
  input wire logic [2:0] nv_lock_in,
  output logic [2:0] nv_lock_set_out,
  output logic [2:0] otp_lock_field_out,
  output logic invert_protection_out
);

  // Software-visible invert bit.
  logic invert_protection_q;

  // Software-visible block protect field.
  logic [2:0] block_protect_field_q;

  // Lock bits; index 0 is security register 1, index 2 is register 3.
  logic [2:0] otp_lock_field_q;

  // Two-stage synchroniser for the non-volatile lock image.
  logic [2:0] nv_meta_q;
  logic [2:0] nv_sync_q;

  // Reset release seen through two flops; high once the image is usable.
  logic img_live_meta_q;
  logic img_live_q;

  // Register read data, valid only in the cycle after a read strobe.
  logic [7:0] reg_rdata_q;

  // Program answer pulses.
  logic prog_ack_q;
  logic prog_reject_q;

  // Pulses telling the non-volatile cells to record a new lock.
  logic [2:0] nv_lock_set_q;

  // Registered protection flag for the block under test.
  logic arr_protected_q;

  // Combinational decisions.
  logic sec_locked;
  logic prog_ok;
  logic prog_last;
  logic [2:0] lock_hit;
  logic [4:0] prot_span;
  logic base_protected;
  logic [7:0] status_two_view;
  logic [7:0] bp_ctrl_view;

  // Effective lock of each user register. The synchronised image is folded
  // in so that a lock restored after reset counts before it reaches the field.
  logic otp_lock_reg1;
  logic otp_lock_reg2;
  logic otp_lock_reg3;

  assign otp_lock_reg1 = otp_lock_field_q[0] | nv_sync_q[0]; // [R9]
  assign otp_lock_reg2 = otp_lock_field_q[1] | nv_sync_q[1]; // [R9]
  assign otp_lock_reg3 = otp_lock_field_q[2] | nv_sync_q[2]; // [R9]

  // The pin image comes from another timing domain, so it passes two
  // flip-flops and only the second one is ever read by logic.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nv_meta_q <= olcp_pkg::LOCK_RST;
      nv_sync_q <= olcp_pkg::LOCK_RST;
    end else begin
      nv_meta_q <= nv_lock_in;
      nv_sync_q <= nv_meta_q;
    end
  end

  // Reset release is asynchronous too, so it walks through two flops of its
  // own. Until the second one is set the lock image may still be on its way
  // in, and a request could slip past a lock that the cells hold; so every
  // request is refused in that span, and in reset itself.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      img_live_meta_q <= 1'h0;
      img_live_q <= 1'h0;
    end else begin
      img_live_meta_q <= 1'h1;
      img_live_q <= img_live_meta_q;
    end
  end

  // Decide whether the addressed security register accepts a byte.
  // Register zero carries factory data and has no lock bit of its own,
  // so it is treated as permanently locked.
  always_comb begin
    case (prog_req_in.sel)
      2'h0: begin
        sec_locked = 1'b1; // [R5]
      end
      2'h1: begin
        sec_locked = otp_lock_reg1; // [R4]
      end
      2'h2: begin
        sec_locked = otp_lock_reg2; // [R4]
      end
      2'h3: begin
        sec_locked = otp_lock_reg3; // [R4]
      end
      default: begin
        sec_locked = 1'b1;
      end
    endcase
  end

  // A request goes through only while its register is still open and the
  // lock image has had time to cross into this clock domain.
  assign prog_ok = prog_valid_in && !sec_locked && img_live_q; // [R4] [R9]

  // The 128th byte is the one that closes a register.
  assign prog_last = prog_req_in.addr == olcp_pkg::SEC_LAST_BYTE; // [R1]

  // One lock per user register, each set by its own last-byte write.
  // Register select 1 maps to index 0, which sits at status bit 3.
  genvar gi;
  generate
    for (gi = 0; gi < olcp_pkg::LOCK_W; gi++) begin : g_lock
      assign lock_hit[gi] = prog_ok && prog_last &&
        (prog_req_in.sel == 2'(gi + 1)); // [R1]
    end
  endgenerate

  // Lock bits only ever gain ones: from a last-byte write or from the
  // stored image. No path clears them apart from the reset, and the
  // stored image restores them right after it.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      otp_lock_field_q <= olcp_pkg::LOCK_RST; // [R3]
    end else begin
      otp_lock_field_q <= otp_lock_field_q | lock_hit | nv_sync_q; // [R9]
    end
  end

  // A new lock is handed to the non-volatile cells as a one-cycle pulse
  // so that it is still set after the next power cycle.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      nv_lock_set_q <= olcp_pkg::LOCK_RST;
    end else begin
      nv_lock_set_q <= lock_hit; // [R9]
    end
  end

  // Answer every program request taken outside reset one cycle later with either an
  // acknowledge or a reject; exactly one of them pulses.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prog_ack_q <= 1'b0;
      prog_reject_q <= 1'b0;
    end else begin
      prog_ack_q <= prog_ok;
      prog_reject_q <= prog_valid_in && !prog_ok; // [R4] [R9]
    end
  end

  // Invert bit: written by software, steers the protection decode.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      invert_protection_q <= olcp_pkg::INV_RST; // [R6]
    end else if (reg_wr_in && reg_addr_in == olcp_pkg::ADDR_STATUS_TWO) begin
      invert_protection_q <= reg_wdata_in[olcp_pkg::INV_BIT]; // [R6]
    end
  end

  // Block protect field: written by software through its own register.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      block_protect_field_q <= olcp_pkg::BP_RST;
    end else if (reg_wr_in && reg_addr_in == olcp_pkg::ADDR_BP_CTRL) begin
      block_protect_field_q <= reg_wdata_in[olcp_pkg::BP_LSB +: olcp_pkg::BP_W];
    end
  end

  // Number of top blocks that the field protects. Values of five and up
  // cover the whole array, a simple and monotonic choice.
  always_comb begin
    case (block_protect_field_q)
      3'h0: begin
        prot_span = 5'h00;
      end
      3'h1: begin
        prot_span = 5'h01;
      end
      3'h2: begin
        prot_span = 5'h02;
      end
      3'h3: begin
        prot_span = 5'h04;
      end
      3'h4: begin
        prot_span = 5'h08;
      end
      default: begin
        prot_span = olcp_pkg::NUM_BLKS;
      end
    endcase
  end

  // A block is protected when it lies in the top span. A span of zero
  // puts the bound above every block, so nothing is protected.
  assign base_protected = {1'b0, arr_block_in} >= (olcp_pkg::NUM_BLKS - prot_span);

  // The invert bit flips the decoded answer for every block, so the
  // protected and the open part of the array trade places.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      arr_protected_q <= 1'b0;
    end else begin
      arr_protected_q <= base_protected ^ invert_protection_q; // [R7] [R8]
    end
  end

  // Read view of the second status register. Bits that belong to other
  // parts of the status logic, and the reserved bit, read as zero.
  always_comb begin
    status_two_view = 8'h00;
    status_two_view[olcp_pkg::INV_BIT] = invert_protection_q; // [R6]
    status_two_view[olcp_pkg::LOCK_LSB +: olcp_pkg::LOCK_W] = otp_lock_field_q; // [R2]
  end

  // Read view of the block protect control register.
  always_comb begin
    bp_ctrl_view = 8'h00;
    bp_ctrl_view[olcp_pkg::BP_LSB +: olcp_pkg::BP_W] = block_protect_field_q;
  end

  // Read data stands only in the cycle after the strobe and is zero
  // otherwise; an unmapped address answers zero.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_q <= olcp_pkg::RDATA_RST;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        olcp_pkg::ADDR_STATUS_TWO: begin
          reg_rdata_q <= status_two_view;
        end
        olcp_pkg::ADDR_BP_CTRL: begin
          reg_rdata_q <= bp_ctrl_view;
        end
        default: begin
          reg_rdata_q <= olcp_pkg::RDATA_RST;
        end
      endcase
    end else begin
      reg_rdata_q <= olcp_pkg::RDATA_RST;
    end
  end

  // Security register bytes. Only an allowed request writes the store,
  // which keeps a locked register read-only whatever the host sends.
  olcp_sec_store u_store (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(prog_ok), // [R4]
    .wr_sel_in(prog_req_in.sel),
    .wr_addr_in(prog_req_in.addr),
    .wr_data_in(prog_req_in.data),
    .rd_en_in(sec_rd_in),
    .rd_sel_in(sec_rd_req_in.sel),
    .rd_addr_in(sec_rd_req_in.addr),
    .rd_data_out(sec_rdata_out)
  );

  // Every output comes straight from a flip-flop.
  assign reg_rdata_out = reg_rdata_q;
  assign prog_ack_out = prog_ack_q;
  assign prog_reject_out = prog_reject_q;
  assign arr_protected_out = arr_protected_q;
  assign nv_lock_set_out = nv_lock_set_q;
  assign otp_lock_field_out = otp_lock_field_q;
  assign invert_protection_out = invert_protection_q;

endmodule

// [tb/olcp_nv_cells_model.sv]
// Model of the non-volatile lock cells that sit beside the lock block.
// Assumes set pulses arrive in the block clock domain; nothing erases a cell.
module olcp_nv_cells_model (
  input wire logic ref_clk_in,
  input wire logic [2:0] lock_set_in,
  output logic [2:0] nv_lock_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cells leave the factory erased, so every user register starts unlocked.
  logic [2:0] cells_q = 3'h0;
  // A set pulse programs its cell for good; no reset reaches these cells.
  always @(posedge ref_clk_in) begin
    cells_q <= cells_q | lock_set_in;
  end
  assign nv_lock_out = cells_q;
endmodule

// [tb/olcp_checker.sv]
// Concurrent checks on the ports of the lock and complement protect top.
// Assumes a single clock domain and an active-low asynchronous reset.
module olcp_checker (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic prog_valid_in,
  input wire olcp_pkg::olcp_prog_req_t prog_req_in,
  input wire logic prog_ack_out,
  input wire logic prog_reject_out,
  input wire logic [3:0] arr_block_in,
  input wire logic arr_protected_out,
  input wire logic [2:0] nv_lock_set_out,
  input wire logic [2:0] otp_lock_field_out,
  input wire logic invert_protection_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  // Edges since reset release, held at three; the lock field only shows the
  // restored image from the third edge on, so the last-byte checks wait for it.
  logic [1:0] settle_q;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      settle_q <= 2'h0;
    end else if (settle_q != 2'h3) begin
      settle_q <= settle_q + 2'h1;
    end
  end
  // A program request aimed at one of the three user registers.
  sequence s_user_req;
    prog_valid_in && prog_req_in.sel != 2'h0;
  endsequence
  // Its last byte, while that register is still open.
  sequence s_fresh_last;
    s_user_req ##0 (settle_q == 2'h3 && prog_req_in.addr == 7'h7F &&
      !otp_lock_field_out[prog_req_in.sel - 2'h1]);
  endsequence
  // Requests in the first two edges after release are always refused.
  property p_early_rej;
    prog_valid_in && settle_q < 2'h2 |=> prog_reject_out;
  endproperty
  a_early_rej: assert property (p_early_rej) else $error("early request taken");
  property p_one_answer;
    prog_valid_in |=> prog_ack_out != prog_reject_out;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("program answer not unique");
  property p_factory_rej;
    prog_valid_in && prog_req_in.sel == 2'h0 |=> prog_reject_out;
  endproperty
  a_factory_rej: assert property (p_factory_rej) else $error("factory register written");
  property p_locked_rej;
    s_user_req ##0 otp_lock_field_out[prog_req_in.sel - 2'h1] |=> prog_reject_out;
  endproperty
  a_locked_rej: assert property (p_locked_rej) else $error("locked register written");
  property p_lock_sets;
    s_fresh_last |=> prog_ack_out && otp_lock_field_out[$past(prog_req_in.sel) - 2'h1];
  endproperty
  a_lock_sets: assert property (p_lock_sets) else $error("last byte did not lock");
  property p_nv_record;
    s_fresh_last |=> nv_lock_set_out == 3'h1 << ($past(prog_req_in.sel) - 2'h1);
  endproperty
  a_nv_record: assert property (p_nv_record) else $error("lock not recorded");
  property p_lock_kept;
    ($past(otp_lock_field_out) & ~otp_lock_field_out) == 3'h0;
  endproperty
  a_lock_kept: assert property (p_lock_kept) else $error("lock bit cleared");
  property p_status_read;
    reg_rd_in && reg_addr_in == olcp_pkg::ADDR_STATUS_TWO |=>
      reg_rdata_out == {1'h0, $past(invert_protection_out), $past(otp_lock_field_out), 3'h0};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");
  property p_inv_write;
    reg_wr_in && reg_addr_in == olcp_pkg::ADDR_STATUS_TWO |=>
      invert_protection_out == $past(reg_wdata_in[6]);
  endproperty
  a_inv_write: assert property (p_inv_write) else $error("invert bit not written");
  // With the block index steady, a flip of the invert bit must flip protection.
  property p_inv_swap;
    $changed(invert_protection_out) && $stable(arr_block_in) |=>
      arr_protected_out != $past(arr_protected_out);
  endproperty
  a_inv_swap: assert property (p_inv_swap) else $error("invert did not swap");
endmodule

bind olcp_top olcp_checker u_chk (.ref_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .prog_valid_in, .prog_req_in, .prog_ack_out,
  .prog_reject_out, .arr_block_in, .arr_protected_out, .nv_lock_set_out,
  .otp_lock_field_out, .invert_protection_out);

// [tb/test_otp_lock_and_complement_protect.sv]
// Self-checking bench for the lock and complement protect top.
// Assumes the lock cell model stands on the non-volatile pins.
module test_otp_lock_and_complement_protect;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'h0, reset_n_in = 1'h0;
  logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, sec_rdata_out;
  logic reg_wr_in = 1'h0, reg_rd_in = 1'h0, prog_valid_in = 1'h0, sec_rd_in = 1'h0;
  logic prog_ack_out, prog_reject_out, arr_protected_out, invert_protection_out;
  olcp_pkg::olcp_prog_req_t prog_req_in = '0;
  olcp_pkg::olcp_sec_rd_t sec_rd_req_in = '0;
  logic [3:0] arr_block_in = 4'h0;
  logic [2:0] nv_lock_in, nv_lock_set_out, otp_lock_field_out;
  int err_count = 0, cmp_count = 0;
  // Rows of {block protect, invert, block index, expected protection}.
  logic [8:0] rows [8] = '{{3'h0, 1'h0, 4'hF, 1'h0}, {3'h1, 1'h0, 4'hF, 1'h1},
    {3'h1, 1'h1, 4'hF, 1'h0}, {3'h1, 1'h1, 4'h0, 1'h1}, {3'h3, 1'h0, 4'hC, 1'h1},
    {3'h3, 1'h0, 4'hB, 1'h0}, {3'h5, 1'h0, 4'h0, 1'h1}, {3'h5, 1'h1, 4'h0, 1'h0}};
  olcp_top uut (.ref_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .prog_valid_in, .prog_req_in, .prog_ack_out,
    .prog_reject_out, .sec_rd_in, .sec_rd_req_in, .sec_rdata_out, .arr_block_in,
    .arr_protected_out, .nv_lock_in, .nv_lock_set_out, .otp_lock_field_out,
    .invert_protection_out);
  olcp_nv_cells_model nv (.ref_clk_in, .lock_set_in(nv_lock_set_out), .nv_lock_out(nv_lock_in));
  // The 10 MHz clock.
  initial forever #50 ref_clk_in = ~ref_clk_in;
  // Compares one value; the four-state compare keeps unknowns from passing.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'h0;
    #1 chk(reg_rdata_out, exp);
  endtask
  task automatic prog(input logic [1:0] s, input logic [6:0] a, input logic acc);
    @(posedge ref_clk_in);
    prog_valid_in <= 1'h1;
    prog_req_in <= '{sel: s, addr: a, data: 8'h5A};
    @(posedge ref_clk_in);
    prog_valid_in <= 1'h0;
    #1 chk(prog_ack_out, acc);
    chk(prog_reject_out, acc ? 8'h00 : 8'h01);
  endtask
  // Security byte read; the byte stands from the edge after the strobe.
  task automatic srd(input logic [1:0] s, input logic [6:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    sec_rd_in <= 1'h1;
    sec_rd_req_in <= '{sel: s, addr: a};
    @(posedge ref_clk_in);
    sec_rd_in <= 1'h0;
    #1 chk(sec_rdata_out, exp);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog sized well beyond the hundred or so cycles the tests take.
  initial begin
    repeat (5000) @(posedge ref_clk_in);
    err_count++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge ref_clk_in);
    reset_n_in <= 1'h1;
    repeat (4) @(posedge ref_clk_in);
    rd(8'h00, 8'h00);
    rd(8'h55, 8'h00);
    foreach (rows[i]) begin
      wr(8'h01, {5'h00, rows[i][8:6]});
      wr(8'h00, {1'h0, rows[i][5], 6'h00});
      arr_block_in <= rows[i][4:1];
      repeat (2) @(posedge ref_clk_in);
      #1 chk(arr_protected_out, rows[i][0]);
      chk(invert_protection_out, rows[i][5]);
    end
    rd(8'h01, 8'h05);
    $display("protection table done");
    prog(2'h0, 7'h10, 1'h0);
    prog(2'h1, 7'h10, 1'h1);
    // Last byte of register 1 followed at once by another byte to it.
    @(posedge ref_clk_in);
    prog_valid_in <= 1'h1;
    prog_req_in <= '{sel: 2'h1, addr: 7'h7F, data: 8'h11};
    @(posedge ref_clk_in);
    prog_req_in <= '{sel: 2'h1, addr: 7'h10, data: 8'h00};
    #1 chk(prog_ack_out, 8'h01);
    chk(otp_lock_field_out, 8'h01);
    chk(nv_lock_set_out, 8'h01);
    @(posedge ref_clk_in);
    prog_valid_in <= 1'h0;
    #1 chk(prog_reject_out, 8'h01);
    srd(2'h1, 7'h10, 8'h5A);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h48);
    prog(2'h3, 7'h7F, 1'h1);
    rd(8'h00, 8'h68);
    $display("lock sequence done");
    // The flops forget on reset; the cell image must bring the locks back.
    // A request in reset, and one at the first edge after it, must not reach
    // register 1, which only the cell image still holds locked.
    reset_n_in <= 1'h0;
    prog_valid_in <= 1'h1;
    prog_req_in <= '{sel: 2'h1, addr: 7'h10, data: 8'h00};
    @(posedge ref_clk_in);
    prog_valid_in <= 1'h0;
    repeat (2) @(posedge ref_clk_in);
    reset_n_in <= 1'h1;
    prog_valid_in <= 1'h1;
    @(posedge ref_clk_in);
    prog_valid_in <= 1'h0;
    #1 chk(prog_reject_out, 8'h01);
    repeat (3) @(posedge ref_clk_in);
    rd(8'h00, 8'h28);
    prog(2'h3, 7'h00, 1'h0);
    prog(2'h2, 7'h00, 1'h1);
    srd(2'h1, 7'h10, 8'h5A);
    $display("reset retention done");
    summarize();
  end
endmodule
